// ---- frame_cfg_pkg.sv ----
package frame_cfg_pkg;

    // Register offsets
    localparam logic [7:0] OFS_RESERVED_B = 8'h0b;
    localparam logic [7:0] OFS_CASCADE = 8'h0c;
    localparam logic [7:0] OFS_EMPTY0_HIGH = 8'h0d;
    localparam logic [7:0] OFS_EMPTY0_MID = 8'h0e;
    localparam logic [7:0] OFS_EMPTY0_LOW = 8'h0f;
    localparam logic [7:0] OFS_EMPTY1_HIGH = 8'h10;
    localparam logic [7:0] OFS_EMPTY1_MID = 8'h11;
    localparam logic [7:0] OFS_EMPTY1_LOW = 8'h12;
    localparam logic [7:0] OFS_FULL0_HIGH = 8'h13;
    localparam logic [7:0] OFS_FULL0_MID = 8'h14;
    localparam logic [7:0] OFS_FULL0_LOW = 8'h15;
    localparam logic [7:0] OFS_FULL1_HIGH = 8'h16;
    localparam logic [7:0] OFS_FULL1_MID = 8'h17;
    localparam logic [7:0] OFS_FULL1_LOW = 8'h18;
    localparam logic [7:0] OFS_COMMIT = 8'h3f;

    // Commit key and field widths
    localparam logic [7:0] COMMIT_KEY = 8'h00;
    localparam int WIDE_BITS = 22;
    localparam int NARROW_BITS = 18;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Cascade field reset values
    localparam logic [3:0] POSITION_RESET = 4'h0;
    localparam logic [3:0] CHIP_COUNT_RESET = 4'h0;

    // Depth per chip in 8-bit words and cascade wrap points
    localparam logic [25:0] CHIP_WORDS = 26'd3880800;
    localparam logic [25:0] MOD_TWO = 26'd7761600;
    localparam logic [25:0] MOD_TWELVE = 26'd23284800;
    localparam logic [3:0] COUNT_TWO = 4'h1;
    localparam logic [3:0] COUNT_TWELVE = 4'hc;

    // Threshold defaults: 1/80 and 79/80 of memory; level 1 low uses half memory, level 1 high is all ones
    localparam logic [21:0] LOW0_DEFAULT = 22'(CHIP_WORDS / 80);
    localparam logic [21:0] HIGH0_DEFAULT = 22'((CHIP_WORDS * 79) / 80);
    localparam logic [17:0] LOW1_DEFAULT = 18'((CHIP_WORDS / 2) / 80);
    localparam logic [17:0] HIGH1_DEFAULT = 18'h3ffff;

    // Serial port
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] DEVICE_ADDRESS = 7'h2a;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_PTR = 4'h2,
        ST_PTR_ACK = 4'h6,
        ST_WRITE = 4'h7,
        ST_WRITE_ACK = 4'h5,
        ST_READ = 4'h4,
        ST_READ_ACK = 4'hc
    } port_state_t;

endpackage

// ---- serial_cfg_port.sv ----
module serial_cfg_port #(
    parameter logic [6:0] DEV_ADDR = frame_cfg_pkg::DEVICE_ADDRESS
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe,
    output logic [7:0] o_ptr,
    output logic o_wr_stb,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata
);
    logic scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d;
    logic rise, fall, start, stop;
    frame_cfg_pkg::port_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shreg, next_shreg, ptr, next_ptr;
    logic oe, next_oe, rw, next_rw, ackd, next_ackd, wr, next_wr;

    // Pin synchronisers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_meta <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_meta <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_meta <= i_scl;
            scl_s <= scl_meta;
            scl_d <= scl_s;
            sda_meta <= i_sda;
            sda_s <= sda_meta;
            sda_d <= sda_s;
        end
    end

    assign rise = scl_s & ~scl_d;
    assign fall = ~scl_s & scl_d;
    assign start = scl_s & scl_d & sda_d & ~sda_s;
    assign stop = scl_s & scl_d & ~sda_d & sda_s;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_ptr = ptr;
        next_oe = oe;
        next_rw = rw;
        next_ackd = ackd;
        next_wr = 1'b0;
        if (start) begin
            next_state = frame_cfg_pkg::ST_ADDR;
            next_cnt = '0;
            next_oe = 1'b0;
        end else if (stop) begin
            next_state = frame_cfg_pkg::ST_IDLE;
            next_oe = 1'b0;
        end else if (rise) begin
            case (state)
                frame_cfg_pkg::ST_ADDR, frame_cfg_pkg::ST_PTR,
                frame_cfg_pkg::ST_WRITE: begin
                    next_shreg = {shreg[6:0], sda_s};
                    next_cnt = cnt + 4'h1;
                end
                frame_cfg_pkg::ST_READ: next_cnt = cnt + 4'h1;
                frame_cfg_pkg::ST_READ_ACK: next_ackd = ~sda_s;
                default: ;
            endcase
        end else if (fall) begin
            case (state)
                frame_cfg_pkg::ST_ADDR: begin
                    if (cnt == frame_cfg_pkg::BITS_PER_BYTE) begin
                        next_cnt = '0;
                        if (shreg[7:1] == DEV_ADDR) begin
                            next_oe = 1'b1;
                            next_rw = shreg[0];
                            next_state = frame_cfg_pkg::ST_ADDR_ACK;
                        end else begin
                            next_state = frame_cfg_pkg::ST_IDLE;
                        end
                    end
                end
                frame_cfg_pkg::ST_ADDR_ACK: begin
                    next_cnt = '0;
                    if (rw) begin
                        next_shreg = i_rdata;
                        next_oe = ~i_rdata[7];
                        next_state = frame_cfg_pkg::ST_READ;
                    end else begin
                        next_oe = 1'b0;
                        next_state = frame_cfg_pkg::ST_PTR;
                    end
                end
                frame_cfg_pkg::ST_PTR: begin
                    if (cnt == frame_cfg_pkg::BITS_PER_BYTE) begin
                        next_ptr = shreg;
                        next_oe = 1'b1;
                        next_cnt = '0;
                        next_state = frame_cfg_pkg::ST_PTR_ACK;
                    end
                end
                frame_cfg_pkg::ST_PTR_ACK: begin
                    next_oe = 1'b0;
                    next_state = frame_cfg_pkg::ST_WRITE;
                end
                frame_cfg_pkg::ST_WRITE: begin
                    if (cnt == frame_cfg_pkg::BITS_PER_BYTE) begin
                        next_wr = 1'b1;
                        next_oe = 1'b1;
                        next_cnt = '0;
                        next_state = frame_cfg_pkg::ST_WRITE_ACK;
                    end
                end
                frame_cfg_pkg::ST_WRITE_ACK: begin
                    next_oe = 1'b0;
                    next_ptr = ptr + 8'h01;
                    next_state = frame_cfg_pkg::ST_WRITE;
                end
                frame_cfg_pkg::ST_READ: begin
                    if (cnt == frame_cfg_pkg::BITS_PER_BYTE) begin
                        next_oe = 1'b0;
                        next_ptr = ptr + 8'h01;
                        next_state = frame_cfg_pkg::ST_READ_ACK;
                    end else begin
                        next_oe = ~shreg[6];
                        next_shreg = {shreg[6:0], 1'b0};
                    end
                end
                frame_cfg_pkg::ST_READ_ACK: begin
                    next_cnt = '0;
                    if (ackd) begin
                        next_shreg = i_rdata;
                        next_oe = ~i_rdata[7];
                        next_state = frame_cfg_pkg::ST_READ;
                    end else begin
                        next_state = frame_cfg_pkg::ST_IDLE;
                    end
                end
                default: next_state = frame_cfg_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= frame_cfg_pkg::ST_IDLE;
            cnt <= '0;
            shreg <= '0;
            ptr <= '0;
            oe <= 1'b0;
            rw <= 1'b0;
            ackd <= 1'b0;
            wr <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            ptr <= next_ptr;
            oe <= next_oe;
            rw <= next_rw;
            ackd <= next_ackd;
            wr <= next_wr;
        end
    end

    assign o_sda_oe = oe;
    assign o_ptr = ptr;
    assign o_wr_stb = wr;
    assign o_wdata = shreg;

endmodule // serial_cfg_port

// ---- frame_fifo_cfg.sv ----
// Function
// - Upper nibble of cascade register gives chip slot; resets to zero.
// - Lower nibble holds cascaded chip count; zero means single device.
// - Count one: addresses wrap modulo 7,761,600 words.
// - Count twelve: addresses wrap modulo 23,284,800 words.
// - 22-bit low-water level drives empty flag 0.
// - Low-water level 0 defaults to one eightieth of memory.
// - Low-water level 0 splits over three bytes, top six bits first.
// - 18-bit low-water level 1 drives empty flag 1 in dual mode.
// - Low-water level 1 defaults to one eightieth of channel memory.
// - Low-water level 1 splits over three bytes, top two bits first.
// - 22-bit high-water level drives full flag 0.
// - High-water level 0 defaults to seventy-nine eightieths of memory.
// - High-water level 0 splits over three bytes, top six bits first.
// - 18-bit high-water level 1 drives full flag 1 in dual mode.
// - High-water level 1 splits over three bytes, top two bits first.
// - Old settings stay active until zero commit, then all transfer.
module frame_fifo_cfg #(
    parameter logic [6:0] DEV_ADDR = frame_cfg_pkg::DEVICE_ADDRESS
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic i_dual_channel,
    input wire logic [21:0] i_word_count_0,
    input wire logic [17:0] i_word_count_1,
    output logic o_partial_empty_flag_0,
    output logic o_partial_empty_flag_1,
    output logic o_partial_full_flag_0,
    output logic o_partial_full_flag_1,
    output logic [3:0] o_chip_position,
    output logic [3:0] o_cascade_chip_count,
    output logic [4:0] o_cascade_total,
    output logic [25:0] o_addr_modulus
);
    logic rst_meta, rst_n, dual_meta, dual_s;
    logic [7:0] ptr, wdata, rdata;
    logic wr_stb, commit;
    // Shadow registers written by the host
    logic [3:0] pos, next_pos, cnt, next_cnt;
    logic [21:0] low0, next_low0, high0, next_high0;
    logic [17:0] low1, next_low1, high1, next_high1;
    // Working registers that drive the flag and cascade outputs
    logic [3:0] pos_w, next_pos_w, cnt_w, next_cnt_w;
    logic [21:0] low0_w, next_low0_w, high0_w, next_high0_w;
    logic [17:0] low1_w, next_low1_w, high1_w, next_high1_w;
    logic pe0, pe1, pf0, pf1, next_pe0, next_pe1, next_pf0, next_pf1;
    logic [25:0] modulus, next_modulus;

    // Reset release and mode pin synchronisers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            dual_meta <= 1'b0;
            dual_s <= 1'b0;
        end else begin
            dual_meta <= i_dual_channel;
            dual_s <= dual_meta;
        end
    end

    serial_cfg_port #(.DEV_ADDR(DEV_ADDR)) u_port (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_sda_oe(o_sda_oe),
        .o_ptr(ptr),
        .o_wr_stb(wr_stb),
        .o_wdata(wdata),
        .i_rdata(rdata)
    );

    assign o_sda = 1'b0;
    assign commit = wr_stb && ptr == frame_cfg_pkg::OFS_COMMIT &&
                    wdata == frame_cfg_pkg::COMMIT_KEY;

    // Shadow register writes; reserved bits are not stored
    always_comb begin
        next_pos = pos;
        next_cnt = cnt;
        next_low0 = low0;
        next_low1 = low1;
        next_high0 = high0;
        next_high1 = high1;
        if (wr_stb) begin
            case (ptr)
                frame_cfg_pkg::OFS_CASCADE: begin
                    next_pos = wdata[7:4];
                    next_cnt = wdata[3:0];
                end
                frame_cfg_pkg::OFS_EMPTY0_HIGH: next_low0[21:16] = wdata[5:0];
                frame_cfg_pkg::OFS_EMPTY0_MID: next_low0[15:8] = wdata;
                frame_cfg_pkg::OFS_EMPTY0_LOW: next_low0[7:0] = wdata;
                frame_cfg_pkg::OFS_EMPTY1_HIGH: next_low1[17:16] = wdata[1:0];
                frame_cfg_pkg::OFS_EMPTY1_MID: next_low1[15:8] = wdata;
                frame_cfg_pkg::OFS_EMPTY1_LOW: next_low1[7:0] = wdata;
                frame_cfg_pkg::OFS_FULL0_HIGH: next_high0[21:16] = wdata[5:0];
                frame_cfg_pkg::OFS_FULL0_MID: next_high0[15:8] = wdata;
                frame_cfg_pkg::OFS_FULL0_LOW: next_high0[7:0] = wdata;
                frame_cfg_pkg::OFS_FULL1_HIGH: next_high1[17:16] = wdata[1:0];
                frame_cfg_pkg::OFS_FULL1_MID: next_high1[15:8] = wdata;
                frame_cfg_pkg::OFS_FULL1_LOW: next_high1[7:0] = wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos <= frame_cfg_pkg::POSITION_RESET;
            cnt <= frame_cfg_pkg::CHIP_COUNT_RESET;
            low0 <= frame_cfg_pkg::LOW0_DEFAULT;
            low1 <= frame_cfg_pkg::LOW1_DEFAULT;
            high0 <= frame_cfg_pkg::HIGH0_DEFAULT;
            high1 <= frame_cfg_pkg::HIGH1_DEFAULT;
        end else begin
            pos <= next_pos;
            cnt <= next_cnt;
            low0 <= next_low0;
            low1 <= next_low1;
            high0 <= next_high0;
            high1 <= next_high1;
        end
    end

    // Read mux; reserved bits and write-only register read zero
    always_comb begin
        case (ptr)
            frame_cfg_pkg::OFS_CASCADE: rdata = {pos, cnt};
            frame_cfg_pkg::OFS_EMPTY0_HIGH: rdata = {2'b00, low0[21:16]};
            frame_cfg_pkg::OFS_EMPTY0_MID: rdata = low0[15:8];
            frame_cfg_pkg::OFS_EMPTY0_LOW: rdata = low0[7:0];
            frame_cfg_pkg::OFS_EMPTY1_HIGH: rdata = {6'h00, low1[17:16]};
            frame_cfg_pkg::OFS_EMPTY1_MID: rdata = low1[15:8];
            frame_cfg_pkg::OFS_EMPTY1_LOW: rdata = low1[7:0];
            frame_cfg_pkg::OFS_FULL0_HIGH: rdata = {2'b00, high0[21:16]};
            frame_cfg_pkg::OFS_FULL0_MID: rdata = high0[15:8];
            frame_cfg_pkg::OFS_FULL0_LOW: rdata = high0[7:0];
            frame_cfg_pkg::OFS_FULL1_HIGH: rdata = {6'h00, high1[17:16]};
            frame_cfg_pkg::OFS_FULL1_MID: rdata = high1[15:8];
            frame_cfg_pkg::OFS_FULL1_LOW: rdata = high1[7:0];
            default: rdata = frame_cfg_pkg::READ_ZERO;
        endcase
    end

    // Working copy, loaded only by the zero commit
    always_comb begin
        next_pos_w = pos_w;
        next_cnt_w = cnt_w;
        next_low0_w = low0_w;
        next_low1_w = low1_w;
        next_high0_w = high0_w;
        next_high1_w = high1_w;
        if (commit) begin
            next_pos_w = pos;
            next_cnt_w = cnt;
            next_low0_w = low0;
            next_low1_w = low1;
            next_high0_w = high0;
            next_high1_w = high1;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_w <= frame_cfg_pkg::POSITION_RESET;
            cnt_w <= frame_cfg_pkg::CHIP_COUNT_RESET;
            low0_w <= frame_cfg_pkg::LOW0_DEFAULT;
            low1_w <= frame_cfg_pkg::LOW1_DEFAULT;
            high0_w <= frame_cfg_pkg::HIGH0_DEFAULT;
            high1_w <= frame_cfg_pkg::HIGH1_DEFAULT;
        end else begin
            pos_w <= next_pos_w;
            cnt_w <= next_cnt_w;
            low0_w <= next_low0_w;
            low1_w <= next_low1_w;
            high0_w <= next_high0_w;
            high1_w <= next_high1_w;
        end
    end

    // Flags and cascade wrap point
    always_comb begin
        next_pe0 = i_word_count_0 <= low0_w;
        next_pf0 = i_word_count_0 >= high0_w;
        next_pe1 = dual_s && i_word_count_1 <= low1_w;
        next_pf1 = dual_s && i_word_count_1 >= high1_w;
        case (cnt_w)
            frame_cfg_pkg::CHIP_COUNT_RESET: next_modulus =
                frame_cfg_pkg::CHIP_WORDS;
            frame_cfg_pkg::COUNT_TWO: next_modulus =
                frame_cfg_pkg::MOD_TWO;
            frame_cfg_pkg::COUNT_TWELVE: next_modulus =
                frame_cfg_pkg::MOD_TWELVE;
            default: next_modulus =
                26'(frame_cfg_pkg::CHIP_WORDS * ({1'b0, cnt_w} + 5'h01));
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pe0 <= 1'b0;
            pe1 <= 1'b0;
            pf0 <= 1'b0;
            pf1 <= 1'b0;
            modulus <= frame_cfg_pkg::CHIP_WORDS;
        end else begin
            pe0 <= next_pe0;
            pe1 <= next_pe1;
            pf0 <= next_pf0;
            pf1 <= next_pf1;
            modulus <= next_modulus;
        end
    end

    assign o_partial_empty_flag_0 = pe0;
    assign o_partial_empty_flag_1 = pe1;
    assign o_partial_full_flag_0 = pf0;
    assign o_partial_full_flag_1 = pf1;
    assign o_chip_position = pos_w;
    assign o_cascade_chip_count = cnt_w;
    assign o_cascade_total = {1'b0, cnt_w} + 5'h01;
    assign o_addr_modulus = modulus;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    position_commit_a: assert property (
        commit |=> o_chip_position == $past(pos))
        else $error("chip position not taken at commit");
    count_commit_a: assert property (
        commit |=> o_cascade_chip_count == $past(cnt))
        else $error("chip count not taken at commit");
    settings_hold_a: assert property (
        !commit |=> $stable({pos_w, cnt_w, low0_w, low1_w, high0_w, high1_w}))
        else $error("working settings changed without commit");
    wrap_two_a: assert property (
        o_cascade_chip_count == frame_cfg_pkg::COUNT_TWO
        |=> o_addr_modulus == frame_cfg_pkg::MOD_TWO)
        else $error("two-chip wrap point wrong");
    wrap_twelve_a: assert property (
        o_cascade_chip_count == frame_cfg_pkg::COUNT_TWELVE
        |=> o_addr_modulus == frame_cfg_pkg::MOD_TWELVE)
        else $error("twelve-chip wrap point wrong");
    empty_flag0_a: assert property (
        rst_n |=> o_partial_empty_flag_0 ==
        ($past(i_word_count_0) <= $past(low0_w)))
        else $error("empty flag 0 wrong");
    full_flag0_a: assert property (
        rst_n |=> o_partial_full_flag_0 ==
        ($past(i_word_count_0) >= $past(high0_w)))
        else $error("full flag 0 wrong");
    channel1_single_a: assert property (
        !dual_s |=> !o_partial_empty_flag_1 && !o_partial_full_flag_1)
        else $error("channel 1 flags active in single mode");
    empty_split_a: assert property (
        wr_stb && ptr == frame_cfg_pkg::OFS_EMPTY0_HIGH
        |=> low0[21:16] == $past(wdata[5:0]))
        else $error("low-water level 0 top bits not stored");
    full1_split_a: assert property (
        wr_stb && ptr == frame_cfg_pkg::OFS_FULL1_HIGH
        |=> high1[17:16] == $past(wdata[1:0]) && rdata[7:2] == 6'h00)
        else $error("high-water level 1 top bits not stored");

    commit_seen_c: cover property (commit ##1 o_cascade_chip_count != 4'h0);
    empty_flag_c: cover property (o_partial_empty_flag_0);
    dual_full_c: cover property (dual_s && o_partial_full_flag_1);
    read_drive_c: cover property (o_sda_oe && !wr_stb);

endmodule // frame_fifo_cfg

// ---- cfg_host.sv ----
module cfg_host (
    input wire logic i_clk,
    input wire logic i_line,
    output logic o_scl,
    output logic o_sda
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic put_bit(input logic b, output logic r);
        o_scl = 1'b0;
        hold(5);
        o_sda = b;
        hold(5);
        o_scl = 1'b1;
        hold(10);
        r = i_line;
    endtask
    task automatic put_byte(input logic [7:0] d, input logic nb,
            output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], r);
            q[i] = r;
        end
        put_bit(nb, r);
    endtask
    task automatic start(input logic rd);
        logic [7:0] q;
        o_sda = 1'b0;
        hold(10);
        put_byte({frame_cfg_pkg::DEVICE_ADDRESS, rd}, 1'b1, q);
    endtask
    task automatic stop();
        o_scl = 1'b0;
        hold(5);
        o_sda = 1'b0;
        hold(5);
        o_scl = 1'b1;
        hold(10);
        o_sda = 1'b1;
        hold(10);
    endtask
    task automatic wr(input logic [7:0] ptr, input int n,
            input logic [23:0] v);
        logic [7:0] q;
        start(1'b0);
        put_byte(ptr, 1'b1, q);
        for (int i = n - 1; i >= 0; i--)
            put_byte(v[8*i +: 8], 1'b1, q);
        stop();
    endtask
    task automatic rd(input logic [7:0] ptr, input int n,
            output logic [23:0] v);
        logic [7:0] q;
        wr(ptr, 0, 24'h0);
        start(1'b1);
        v = 24'h0;
        for (int i = n - 1; i >= 0; i--) begin
            put_byte(8'hff, i == 0, q);
            v[8*i +: 8] = q;
        end
        stop();
    endtask
    task automatic commit();
        wr(frame_cfg_pkg::OFS_COMMIT, 1, 24'h0);
    endtask
endmodule // cfg_host

// ---- test_frame_fifo_cfg.sv ----
module test_frame_fifo_cfg;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, dual, scl, sda_h, sda_oe, sda_d;
    logic [21:0] cnt0;
    logic [17:0] cnt1;
    logic [3:0] pos, ccnt, flags;
    logic [4:0] total;
    logic [25:0] modulus;
    logic [21:0] sh[4], wk[4];
    logic [23:0] rv;
    integer seed = 32'h7abc6b0e;
    int n_mismatch = 0;
    int check_count = 0;
    wire logic line = sda_h & (~sda_oe | sda_d);
    frame_fifo_cfg DUT (.i_clk(clk), .i_rstn(rstn), .i_scl(scl),
        .i_sda(line), .o_sda(sda_d), .o_sda_oe(sda_oe),
        .i_dual_channel(dual), .i_word_count_0(cnt0),
        .i_word_count_1(cnt1), .o_partial_empty_flag_0(flags[3]),
        .o_partial_empty_flag_1(flags[2]), .o_partial_full_flag_0(flags[1]),
        .o_partial_full_flag_1(flags[0]), .o_chip_position(pos),
        .o_cascade_chip_count(ccnt), .o_cascade_total(total),
        .o_addr_modulus(modulus));
    cfg_host host (.i_clk(clk), .i_line(line), .o_scl(scl), .o_sda(sda_h));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input logic [25:0] seen, input logic [25:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    function automatic logic [25:0] exp_flags();
        return 26'({cnt0 <= wk[0], dual && cnt1 <= wk[1][17:0],
            cnt0 >= wk[2], dual && cnt1 >= wk[3][17:0]});
    endfunction
    function automatic logic [25:0] exp_mod(input int c);
        if (c == 1)
            return 26'd7761600;
        if (c == 12)
            return 26'd23284800;
        return 26'(int'(frame_cfg_pkg::CHIP_WORDS) * (c + 1));
    endfunction
    task automatic probe(input logic [21:0] c0, input logic [21:0] c1);
        @(negedge clk);
        cnt0 = c0;
        cnt1 = c1[17:0];
        repeat (5) @(negedge clk);
        check(26'(flags), exp_flags());
    endtask
    initial begin
        int c;
        logic [21:0] d;
        logic [3:0] p;
        rstn = 1'b0;
        dual = 1'b0;
        cnt0 = 22'h0;
        cnt1 = 18'h0;
        wk[0] = 22'(int'(frame_cfg_pkg::CHIP_WORDS) / 80);
        wk[1] = 22'(int'(frame_cfg_pkg::CHIP_WORDS) / 160);
        wk[2] = 22'(int'(frame_cfg_pkg::CHIP_WORDS) * 79 / 80);
        wk[3] = 22'h3ffff;
        sh = wk;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (8) @(negedge clk);
        check(26'({pos, ccnt}), 26'h0);
        check(26'(total), 26'h1);
        check(modulus, 26'(frame_cfg_pkg::CHIP_WORDS));
        for (int i = 0; i < 4; i++) begin
            host.rd(8'h0d + 8'(3 * i), 3, rv);
            check(26'(rv), 26'(sh[i]));
        end
        host.rd(frame_cfg_pkg::OFS_RESERVED_B, 1, rv);
        check(26'(rv), 26'h0);
        probe(wk[0], wk[1]);
        $display("reset test done");
        for (int k = 0; k < 6; k++) begin
            dual = k[0];
            for (int i = 0; i < 4; i++) begin
                rv = 24'($random(seed)) & (i[0] ? 24'h3ffff : 24'h3fffff);
                sh[i] = rv[21:0];
                host.wr(8'h0d + 8'(3 * i), 3, rv);
            end
            host.wr(frame_cfg_pkg::OFS_COMMIT, 1, 24'h5a);
            probe(sh[0], sh[1]);
            host.commit();
            wk = sh;
            d = 22'($unsigned($random(seed)) % 2);
            probe(wk[0] + d, wk[1] + d);
            probe(wk[2] - d, wk[3] - d);
            host.rd(8'h0d + 8'(3 * (k % 4)), 3, rv);
            check(26'(rv), 26'(sh[k%4]));
        end
        $display("threshold test done");
        for (int k = 0; k < 5; k++) begin
            c = (k == 0) ? 1 : (k == 1) ? 12 :
                int'($unsigned($random(seed)) % 6);
            p = 4'($unsigned($random(seed)) % (c + 1));
            host.wr(frame_cfg_pkg::OFS_CASCADE, 1, 24'({p, 4'(c)}));
            host.commit();
            repeat (4) @(negedge clk);
            check(26'({pos, ccnt}), 26'({p, 4'(c)}));
            check(26'(total), 26'(c + 1));
            check(modulus, exp_mod(c));
        end
        $display("cascade test done");
        give_verdict();
    end
    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
endmodule // test_frame_fifo_cfg
